/* File: rtl/occ_top.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Each channel picks one of two timers
// - Timer select is control bit 3
// - Select zero uses time base A
// - Modes 1,2,3: force low, high, toggle
// - Act when primary equals selected count
// - Timer wrap without match holds pin
// - Modes 4,5: single and continuous pulses
// - Primary first match, secondary second match
// - Rewriting mode 4 gives another pulse
// - Each channel has own control register
module occ_top import occ_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [15:0] time_base_a,
  input wire logic [15:0] time_base_b,
  output logic compare_output_pin_1,
  output logic compare_output_pin_2
);
  logic [15:0] channel_control_register [2];
  logic [15:0] primary_compare_value [2];
  logic [15:0] secondary_compare_value [2];
  logic [1:0] arm;
  logic [1:0] pin;
  occ_state_t state [2];
  logic [31:0] timers_sync;
  logic ack;
  logic [31:0] next_readdata;

  // Timer counts come from another block's pins; resync them
  occ_sync2 #(.WIDTH(32)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in({time_base_b, time_base_a}),
    .sync_out(timers_sync)
  );

  // One wait state, then acknowledge; waitrequest is a flop so the bus never sees a glitch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else if (ce) begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end
  // Acknowledge edge: the one at which waitrequest stands low
  assign ack = !waitrequest;

  for (genvar i = 0; i < 2; i++) begin : g_ch
    // own control and compare registers per channel
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        channel_control_register[i] <= OCC_CTRL_RST;
        primary_compare_value[i] <= OCC_CMP_RST;
        secondary_compare_value[i] <= OCC_CMP_RST;
        arm[i] <= 1'b0;
      end else if (ce) begin
        arm[i] <= 1'b0;
        // Writes land only at the edge where waitrequest is low
        if (write && ack) begin
          if (address == 4'(OCC_CTRL1_OFS + 4'(3 * i))) begin
            channel_control_register[i] <= {12'h000, writedata[3:0]};
            // writing single-pulse or continuous mode arms a pulse
            arm[i] <= (writedata[2:0] == OCC_M_SINGLE) || (writedata[2:0] == OCC_M_CONT);
          end
          if (address == 4'(OCC_PRI1_OFS + 4'(3 * i))) primary_compare_value[i] <= writedata[15:0];
          if (address == 4'(OCC_SEC1_OFS + 4'(3 * i))) secondary_compare_value[i] <= writedata[15:0];
        end
      end
    end

    occ_channel u_ch (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .ctrl(channel_control_register[i]),
      .arm(arm[i]),
      .primary_compare_value(primary_compare_value[i]),
      .secondary_compare_value(secondary_compare_value[i]),
      .time_base_a(timers_sync[15:0]),
      .time_base_b(timers_sync[31:16]),
      .pin(pin[i]),
      .state(state[i])
    );
  end

  // Read mux; control word also shows the live pin level
  always_comb begin
    next_readdata = 32'h0000_0000;
    unique case (address)
      OCC_CTRL1_OFS: next_readdata = {16'h0000, pin[0], channel_control_register[0][14:0]};
      OCC_PRI1_OFS: next_readdata = {16'h0000, primary_compare_value[0]};
      OCC_SEC1_OFS: next_readdata = {16'h0000, secondary_compare_value[0]};
      OCC_CTRL2_OFS: next_readdata = {16'h0000, pin[1], channel_control_register[1][14:0]};
      OCC_PRI2_OFS: next_readdata = {16'h0000, primary_compare_value[1]};
      OCC_SEC2_OFS: next_readdata = {16'h0000, secondary_compare_value[1]};
      OCC_STAT_OFS: next_readdata = {26'h0, state[1], state[0]};
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (ce && read && !ack) begin
      readdata <= next_readdata;
    end
  end

  // Pins come straight from channel flops
  assign compare_output_pin_1 = pin[0];
  assign compare_output_pin_2 = pin[1];

  a_ctrl_write: assert property (@(posedge clk) disable iff (rst)
    ce && write && ack && address == OCC_CTRL1_OFS |=> channel_control_register[0][3:0] == $past(writedata[3:0]))
    else $error("control write lost");
  a_arm_pulse: assert property (@(posedge clk) disable iff (rst)
    ce && write && ack && address == OCC_CTRL1_OFS && writedata[2:0] == OCC_M_SINGLE |=> arm[0])
    else $error("arm missing");
  c_bus_read: cover property (@(posedge clk) read && !waitrequest);
endmodule : occ_top

/* File: rtl/occ_pkg.sv */
package occ_pkg;
  // Register word offsets (word addresses on the Avalon word bus)
  localparam logic [3:0] OCC_CTRL1_OFS = 4'h0;
  localparam logic [3:0] OCC_PRI1_OFS = 4'h1;
  localparam logic [3:0] OCC_SEC1_OFS = 4'h2;
  localparam logic [3:0] OCC_CTRL2_OFS = 4'h3;
  localparam logic [3:0] OCC_PRI2_OFS = 4'h4;
  localparam logic [3:0] OCC_SEC2_OFS = 4'h5;
  localparam logic [3:0] OCC_STAT_OFS = 4'h6;
  // Control register field positions
  localparam int OCC_MODE_LSB = 0;
  localparam int OCC_TSEL_BIT = 3;
  localparam int OCC_PIN_BIT = 15;
  // Reset values
  localparam logic [15:0] OCC_CTRL_RST = 16'h0000;
  localparam logic [15:0] OCC_CMP_RST = 16'h0000;
  // Compare mode field encodings
  localparam logic [2:0] OCC_M_OFF = 3'h0;
  localparam logic [2:0] OCC_M_LOW = 3'h1;
  localparam logic [2:0] OCC_M_HIGH = 3'h2;
  localparam logic [2:0] OCC_M_TOGGLE = 3'h3;
  localparam logic [2:0] OCC_M_SINGLE = 3'h4;
  localparam logic [2:0] OCC_M_CONT = 3'h5;
  // Pulse sequencer states
  typedef enum logic [2:0] {
    OCC_S_IDLE = 3'b001,
    OCC_S_WAIT_PRI = 3'b010,
    OCC_S_WAIT_SEC = 3'b100
  } occ_state_t;
endpackage : occ_pkg

/* File: rtl/occ_sync2.sv */
`timescale 1ns/100ps
// Two-stage synchroniser for a bus of asynchronous levels
module occ_sync2 import occ_pkg::*; #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : occ_sync2

/* File: rtl/occ_channel.sv */
`timescale 1ns/100ps
// One compare channel: match detection and pin action
module occ_channel import occ_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [15:0] ctrl,
  input wire logic arm,
  input wire logic [15:0] primary_compare_value,
  input wire logic [15:0] secondary_compare_value,
  input wire logic [15:0] time_base_a,
  input wire logic [15:0] time_base_b,
  output logic pin,
  output occ_state_t state
);
  logic [2:0] mode;
  logic [15:0] count;
  logic [15:0] last_count;
  logic advanced;
  logic hit_pri;
  logic hit_sec;

  assign mode = ctrl[OCC_MODE_LSB +: 3];
  // select bit picks timer; zero gives A
  assign count = ctrl[OCC_TSEL_BIT] ? time_base_b : time_base_a;
  // Only act when the count moved, so a stopped timer matches once
  assign advanced = (count != last_count);
  assign hit_pri = advanced && (count == primary_compare_value);
  assign hit_sec = advanced && (count == secondary_compare_value);

  // Track the previous count to detect movement
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_count <= OCC_CMP_RST;
    end else if (ce) begin
      last_count <= count;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= OCC_S_IDLE;
    end else if (ce) begin
      if (arm) begin
        // a mode write re-arms one more pulse
        state <= OCC_S_WAIT_PRI;
      end else if (mode != OCC_M_SINGLE && mode != OCC_M_CONT) begin
        state <= OCC_S_IDLE;
      end else begin
        unique case (state)
          OCC_S_IDLE: state <= OCC_S_IDLE;
          OCC_S_WAIT_PRI: if (hit_pri) state <= OCC_S_WAIT_SEC;
          OCC_S_WAIT_SEC: if (hit_sec) state <= (mode == OCC_M_CONT) ? OCC_S_WAIT_PRI : OCC_S_IDLE;
          default: state <= OCC_S_IDLE;
        endcase
      end
    end
  end

  // Pin action; an arm drives it low, otherwise no match means level is held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin <= 1'b0;
    end else if (ce) begin
      if (arm) begin
        pin <= 1'b0;
      end else begin
        unique case (mode)
          OCC_M_LOW: if (hit_pri) pin <= 1'b0;
          OCC_M_HIGH: if (hit_pri) pin <= 1'b1;
          OCC_M_TOGGLE: if (hit_pri) pin <= ~pin;
          // dual modes; high on primary, low on secondary
          OCC_M_SINGLE, OCC_M_CONT: begin
            if (state == OCC_S_WAIT_PRI && hit_pri) pin <= 1'b1;
            else if (state == OCC_S_WAIT_SEC && hit_sec) pin <= 1'b0;
          end
          default: pin <= pin;
        endcase
      end
    end
  end

  // level holds without an arm, a primary match or a secondary match
  a_hold_no_match: assert property (@(posedge clk) disable iff (rst)
    ce && !arm && !hit_pri && !hit_sec |=> $stable(pin)) else $error("pin moved without match");
  a_high_action: assert property (@(posedge clk) disable iff (rst)
    ce && !arm && mode == OCC_M_HIGH && hit_pri |=> pin) else $error("force high failed");
  a_low_action: assert property (@(posedge clk) disable iff (rst)
    ce && !arm && mode == OCC_M_LOW && hit_pri |=> !pin) else $error("force low failed");
  a_toggle_action: assert property (@(posedge clk) disable iff (rst)
    ce && !arm && mode == OCC_M_TOGGLE && hit_pri |=> pin != $past(pin)) else $error("toggle failed");
  a_pulse_rise: assert property (@(posedge clk) disable iff (rst)
    ce && !arm && mode == OCC_M_SINGLE && state == OCC_S_WAIT_PRI && hit_pri |=> pin && state == OCC_S_WAIT_SEC)
    else $error("pulse start wrong");
  // single pulse ends idle and low
  a_single_end: assert property (@(posedge clk) disable iff (rst)
    ce && !arm && mode == OCC_M_SINGLE && state == OCC_S_WAIT_SEC && hit_sec |=> !pin && state == OCC_S_IDLE)
    else $error("single pulse end wrong");
  a_cont_loop: assert property (@(posedge clk) disable iff (rst)
    ce && !arm && mode == OCC_M_CONT && state == OCC_S_WAIT_SEC && hit_sec |=> state == OCC_S_WAIT_PRI)
    else $error("continuous loop broken");
  a_arm_start: assert property (@(posedge clk) disable iff (rst)
    ce && arm |=> state == OCC_S_WAIT_PRI && !pin) else $error("arm failed");
  // with select zero, base A reaching the primary value must act
  a_base_default: assert property (@(posedge clk) disable iff (rst)
    ce && !arm && !ctrl[OCC_TSEL_BIT] && mode == OCC_M_HIGH && advanced && time_base_a == primary_compare_value
    |=> pin) else $error("wrong time base");
  c_single: cover property (@(posedge clk) mode == OCC_M_SINGLE && state == OCC_S_WAIT_SEC ##[1:200] state == OCC_S_IDLE);
  c_cont: cover property (@(posedge clk) mode == OCC_M_CONT && hit_sec ##[1:200] hit_pri);
  c_toggle: cover property (@(posedge clk) mode == OCC_M_TOGGLE && hit_pri);
endmodule : occ_channel

/* File: bench/occ_load.sv */
`timescale 1ns/100ps
// Load on a compare pin: counts the rising edges that it sees
module occ_load (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic [7:0] edges
);
  logic last;
  // Edge counter; a pulse shorter than one clock would be missed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last <= 1'b0;
      edges <= 8'h00;
    end else begin
      last <= pin;
      if (pin && !last) edges <= edges + 8'h01;
    end
  end
endmodule : occ_load

/* File: bench/testbench.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench import occ_pkg::*; ();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic [31:0] rdv;
  logic waitrequest;
  logic [15:0] ta = 16'h0000;
  logic [15:0] tb = 16'h0000;
  logic p1, p2;
  logic [7:0] e1, e2, base;
  int n_errors = 0;
  int n_compared = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  occ_top uut (.clk(clk), .rst(rst), .ce(ce), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .time_base_a(ta),
    .time_base_b(tb), .compare_output_pin_1(p1), .compare_output_pin_2(p2));
  occ_load ld1 (.clk(clk), .rst(rst), .pin(p1), .edges(e1));
  occ_load ld2 (.clk(clk), .rst(rst), .pin(p2), .edges(e2));

  // Verdict and end of run
  task test_done;
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  // One bus access; entered just after a rising edge, holds until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
    address <= a;
    writedata <= {16'h0000, d};
    write <= wr;
    read <= !wr;
    // Only the watchdog ends a wait that never finishes
    do begin @(posedge clk); end while (waitrequest !== 1'b0);
    rdv = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask : bus

  // Walks a timer through counts; the pin needs three cycles to follow
  task step(input logic sel, input int from, input int upto);
    for (int v = from; v <= upto; v++) begin
      if (sel) tb <= v[15:0];
      else ta <= v[15:0];
      repeat (8) @(posedge clk);
    end
  endtask : step

  // Reset values and an unmapped place
  task t_reset;
    bus(1'b0, OCC_CTRL1_OFS, 16'h0000); `CHK(rdv, 32'h00000000)
    bus(1'b0, OCC_SEC2_OFS, 16'h0000); `CHK(rdv, 32'h00000000)
    bus(1'b1, 4'h9, 16'hFFFF);
    bus(1'b0, 4'h9, 16'h0000); `CHK(rdv, 32'h00000000)
    `CHK(p1, 1'b0)
  endtask : t_reset

  // Simple match modes on channel 1, time base A by default
  task t_simple;
    bus(1'b1, OCC_PRI1_OFS, 16'h0005);
    bus(1'b1, OCC_CTRL1_OFS, {13'h0000, OCC_M_HIGH});
    step(1'b0, 0, 4); `CHK(p1, 1'b0)
    step(1'b0, 5, 6); `CHK(p1, 1'b1)
    bus(1'b1, OCC_CTRL1_OFS, {13'h0000, OCC_M_LOW});
    step(1'b0, 0, 6); `CHK(p1, 1'b0)
    bus(1'b1, OCC_CTRL1_OFS, {13'h0000, OCC_M_TOGGLE});
    step(1'b0, 0, 6); `CHK(p1, 1'b1)
    step(1'b0, 0, 6); `CHK(p1, 1'b0)
    // Clock enable low freezes the channel: a pass through the match must not toggle
    ce <= 1'b0;
    step(1'b0, 0, 6); `CHK(p1, 1'b0)
    ce <= 1'b1;
    // Wrap before the match must not toggle
    step(1'b0, 0, 3);
    step(1'b0, 0, 3); `CHK(p1, 1'b0)
    step(1'b0, 4, 5); `CHK(p1, 1'b1)
    `CHK(p2, 1'b0)
  endtask : t_simple

  // Channel 2 on time base B ignores time base A
  task t_select;
    bus(1'b1, OCC_PRI2_OFS, 16'h0007);
    bus(1'b1, OCC_CTRL2_OFS, 16'h000A);
    step(1'b0, 0, 9); `CHK(p2, 1'b0)
    step(1'b1, 0, 7); `CHK(p2, 1'b1)
    bus(1'b0, OCC_CTRL2_OFS, 16'h0000); `CHK(rdv[14:0], 15'h000A)
  endtask : t_select

  // Single pulses on channel 1, re-armed by a second mode write
  task t_single;
    step(1'b0, 0, 0);
    bus(1'b1, OCC_PRI1_OFS, 16'h0003);
    bus(1'b1, OCC_SEC1_OFS, 16'h0006);
    base = e1;
    for (int n = 0; n < 2; n++) begin
      // arm with the timer stopped at zero
      bus(1'b1, OCC_CTRL1_OFS, {13'h0000, OCC_M_SINGLE});
      step(1'b0, 1, 2); `CHK(p1, 1'b0)
      step(1'b0, 3, 5); `CHK(p1, 1'b1)
      step(1'b0, 6, 7); `CHK(p1, 1'b0)
      step(1'b0, 0, 7); `CHK(p1, 1'b0)
      step(1'b0, 0, 0);
    end
    `CHK(e1, base + 8'h02)
    // Sequencer rests idle once the pulse is done
    bus(1'b0, OCC_STAT_OFS, 16'h0000); `CHK(rdv[2:0], 3'(OCC_S_IDLE))
  endtask : t_single

  // Continuous pulses on channel 2, time base B
  task t_cont;
    step(1'b1, 0, 0);
    bus(1'b1, OCC_PRI2_OFS, 16'h0002);
    bus(1'b1, OCC_SEC2_OFS, 16'h0004);
    // mode written before the timer runs
    bus(1'b1, OCC_CTRL2_OFS, {12'h000, 1'b1, OCC_M_CONT});
    base = e2;
    step(1'b1, 1, 3); `CHK(p2, 1'b1)
    step(1'b1, 4, 7);
    for (int n = 0; n < 2; n++) step(1'b1, 0, 7);
    `CHK(e2, base + 8'h03)
    `CHK(p2, 1'b0)
  endtask : t_cont

  // Main sequence: reset for ten cycles, then each scenario
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_simple;
    t_select;
    t_single;
    t_cont;
    test_done();
  end

  // Watchdog, well beyond the thousand or so cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end
endmodule : testbench
